// file: adc_ctrl_pkg.sv
/*
 * Constants shared by the converter control block: register offsets,
 * configuration field positions, reset values, timing counts and state types.
 * Assumes a 50 MHz system clock and a 32-bit APB register bus.
 */
package adc_ctrl_pkg;
    // system clock
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;

    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;

    // configuration field positions
    localparam int CFG_W = 10;
    localparam int CFG_PD_LSB = 0;
    localparam int CFG_FULL_CLOCK = 2;
    localparam int CFG_COUNTER_EN = 3;
    localparam int CFG_CHANNEL_ID_DISABLE = 4;
    localparam int CFG_SINGLE_START = 5;
    localparam int CFG_FIFO_REQ = 6;
    localparam int CFG_SEQ_EN = 7;
    localparam int CFG_SEQ_LAST_LSB = 8;
    localparam logic [9:0] CONFIG_RESET = 10'h000;

    // power-down select encodings
    localparam logic [1:0] PD_NONE = 2'h0;
    localparam logic [1:0] PD_POWER_DOWN = 2'h1;
    localparam logic [1:0] PD_SLEEP = 2'h2;
    localparam logic [1:0] PD_AUTO_SLEEP = 2'h3;

    // new-result counter
    localparam logic [1:0] COUNTER_RESET = 2'h1;

    // conversion timing in converter clock periods
    localparam logic [5:0] CYCLE_HALF = 6'h14;
    localparam logic [5:0] CYCLE_FULL = 6'h28;
    localparam logic [5:0] BUSY_HALF = 6'h12;
    localparam logic [5:0] BUSY_FULL = 6'h24;
    localparam logic [5:0] SETTLE_HALF = 6'h07;
    localparam logic [5:0] SETTLE_FULL = 6'h0E;

    // power sequencing times
    localparam int T_PD_ENTER_US = 20;
    localparam int T_SLEEP_ENTER_US = 10;
    localparam int T_PD_WAKE_MS = 8;
    localparam int T_SRST_NS = 20;
    localparam int PTMR_W = 20;
    localparam int PD_ENTER_CYC = T_PD_ENTER_US * CLK_MHZ;
    localparam int SLEEP_ENTER_CYC = T_SLEEP_ENTER_US * CLK_MHZ;
    localparam int PD_WAKE_CYC = T_PD_WAKE_MS * 1000 * CLK_MHZ;
    localparam int SRST_CYC_RAW = (T_SRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRST_CYC = (SRST_CYC_RAW < 1) ? 1 : SRST_CYC_RAW;

    // serial control word
    localparam logic [4:0] SDI_WORD_BITS = 5'h10;
    localparam logic [3:0] SDI_ADDR_SOFT_RESET = 4'h4;
    localparam logic [3:0] SDI_ADDR_CONFIG = 4'h1;

    // serial output frame
    localparam logic [4:0] FRAME_BITS = 5'h14;

    typedef enum logic [1:0] {C_IDLE, C_SETTLE, C_CONV} conv_state_e;
    typedef enum logic [1:0] {P_ON, P_ENTER, P_OFF, P_WAKE} pwr_state_e;
endpackage : adc_ctrl_pkg

// file: adc_power_counter_readout_ctrl.sv
/*
 * Digital control of a dual simultaneous-sampling converter: conversion and
 * readout timing, new-result counter, power-down sequencing, serial control
 * word with software reset, and an APB register slave.
 * Assumes converter clock, conversion start, read strobe and serial data in
 * arrive asynchronously from the host; result words come from the analog core.
 */
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adc_power_counter_readout_ctrl #(
    parameter int PD_WAKE_CYCLES = adc_ctrl_pkg::PD_WAKE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_clock,
    input wire logic conversion_start,
    input wire logic read_strobe,
    input wire logic serial_data_in,
    input wire logic [15:0] result_a,
    input wire logic [15:0] result_b,
    input wire logic channel_a,
    input wire logic channel_b,
    output logic busy,
    output logic [1:0] serial_data_outputs,
    output logic serial_data_enable,
    output logic fifo_enable,
    output logic sample_mode,
    output logic bias_enable,
    output logic low_current,
    output logic deep_power_down
);
    import adc_ctrl_pkg::*;

    // pin synchronisers: 0 clock, 1 start, 2 read, 3 serial in
    logic [3:0] pins;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] filt_r;
    logic [3:0] filt_d_r;
    logic ck_rise, ck_fall, cs_rise, rd_fall, sdi_bit;

    assign pins = {serial_data_in, read_strobe, conversion_start, adc_clock};

    always_ff @(posedge clk) begin
        sync1_r <= pins;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (rst) begin
                    filt_r[gi] <= 1'b0;
                end else if (sync2_r[gi] == sync3_r[gi]) begin
                    filt_r[gi] <= sync3_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            filt_d_r <= 4'h0;
        end else begin
            filt_d_r <= filt_r;
        end
    end

    assign ck_rise = filt_r[0] & ~filt_d_r[0];
    assign ck_fall = ~filt_r[0] & filt_d_r[0];
    assign cs_rise = filt_r[1] & ~filt_d_r[1];
    assign rd_fall = ~filt_r[2] & filt_d_r[2];
    assign sdi_bit = filt_r[3];

    // software reset stretcher and internal reset
    logic [3:0] srst_cnt_r;
    logic ireset;
    logic soft_req;

    always_ff @(posedge clk) begin
        if (rst) begin
            srst_cnt_r <= 4'h0;
        end else if (soft_req) begin
            srst_cnt_r <= 4'(SRST_CYC);
        end else if (srst_cnt_r != 4'h0) begin
            srst_cnt_r <= srst_cnt_r - 4'h1;
        end
    end
    assign ireset = rst | (srst_cnt_r != 4'h0);

    // configuration fields
    logic [CFG_W-1:0] config_r;
    logic [CFG_W-1:0] config_nxt;
    logic [1:0] pd_sel;
    logic full_clock, counter_en, channel_id_disable, single_start, seq_en;
    logic [1:0] seq_last;

    assign pd_sel = config_r[CFG_PD_LSB +: 2];
    assign full_clock = config_r[CFG_FULL_CLOCK];
    assign counter_en = config_r[CFG_COUNTER_EN];
    assign channel_id_disable = config_r[CFG_CHANNEL_ID_DISABLE];
    assign single_start = config_r[CFG_SINGLE_START];
    assign seq_en = config_r[CFG_SEQ_EN];
    assign seq_last = config_r[CFG_SEQ_LAST_LSB +: 2];

    assign fifo_enable = config_r[CFG_FIFO_REQ] & ~full_clock;

    // mode-dependent lengths
    logic [5:0] cycle_len, busy_len, settle_len;
    assign cycle_len = full_clock ? CYCLE_FULL : CYCLE_HALF;
    assign busy_len = full_clock ? BUSY_FULL : BUSY_HALF;
    assign settle_len = full_clock ? SETTLE_FULL : SETTLE_HALF;

    // serial control word capture
    logic [4:0] sdi_bits_r;
    logic [15:0] sdi_sh_r;
    logic word_done;
    logic [15:0] word;
    logic sdi_cfg_wr;
    logic asleep_r;

    assign word_done = ck_fall & (sdi_bits_r == 5'h01) & ~rd_fall;
    assign word = {sdi_sh_r[14:0], sdi_bit};
    // reset address decoded at word completion
    assign soft_req = word_done & (word[15:12] == SDI_ADDR_SOFT_RESET);
    // while asleep only a write clearing the select field is taken
    assign sdi_cfg_wr = word_done & (word[15:12] == SDI_ADDR_CONFIG)
                        & (~asleep_r | (word[CFG_PD_LSB +: 2] == PD_NONE));

    always_ff @(posedge clk) begin
        if (ireset) begin
            sdi_bits_r <= 5'h00;
            sdi_sh_r <= 16'h0000;
        end else if (rd_fall) begin
            sdi_bits_r <= SDI_WORD_BITS;
        end else if (ck_fall && sdi_bits_r != 5'h00) begin
            sdi_sh_r <= word;
            sdi_bits_r <= sdi_bits_r - 5'h01;
        end
    end

    // APB slave
    logic apb_setup, apb_access, apb_cfg_wr, mapped;
    logic [31:0] rd_mux;
    logic [31:0] prdata_r;
    logic [1:0] cnt_r;
    logic [31:0] result_r;

    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign mapped = (paddr == ADDR_CONFIG) | (paddr == ADDR_STATUS)
                    | (paddr == ADDR_RESULT);
    assign apb_cfg_wr = apb_access & pwrite & (paddr == ADDR_CONFIG);
    assign pready = 1'b1;
    assign pslverr = apb_access & ~mapped;
    assign prdata = prdata_r;
    assign rd_mux = (paddr == ADDR_CONFIG) ? {22'h000000, config_r} :
                    (paddr == ADDR_STATUS) ? {25'h0000000, cnt_r, fifo_enable,
                                              deep_power_down, low_current,
                                              asleep_r, busy} :
                    (paddr == ADDR_RESULT) ? result_r : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    // select field takes effect when the write completes; config untouched by power modes
    assign config_nxt = apb_cfg_wr ? pwdata[CFG_W-1:0] :
                        sdi_cfg_wr ? word[CFG_W-1:0] : config_r;

    always_ff @(posedge clk) begin
        if (ireset) begin
            config_r <= CONFIG_RESET;
        end else begin
            config_r <= config_nxt;
        end
    end

    // conversion sequencing
    conv_state_e cst_r, cst_nxt;
    pwr_state_e pwr_r, pwr_nxt;
    logic [5:0] ccnt_r, ccnt_nxt;
    logic [5:0] since_r;
    logic [1:0] seq_idx_r, seq_nxt;
    logic asleep_nxt, conv_done, start_ok, seq_more, pd_hold;

    assign pd_hold = (pd_sel == PD_POWER_DOWN) | (pd_sel == PD_SLEEP);
    assign start_ok = cs_rise & (cst_r == C_IDLE) & (since_r >= cycle_len)
                      & (pwr_r == P_ON) & ~pd_hold;
    // single start runs the whole sequence
    assign seq_more = seq_en & single_start & (seq_idx_r != seq_last);

    always_comb begin
        cst_nxt = cst_r;
        ccnt_nxt = ccnt_r;
        seq_nxt = seq_idx_r;
        asleep_nxt = asleep_r;
        conv_done = 1'b0;
        case (cst_r)
            C_IDLE: begin
                if (start_ok) begin
                    seq_nxt = 2'h0;
                    // a conversion start wakes auto-sleep, as does leaving the auto-sleep select
                    if (asleep_r) begin
                        cst_nxt = C_SETTLE;
                        ccnt_nxt = settle_len;
                        asleep_nxt = 1'b0;
                    end else begin
                        cst_nxt = C_CONV;
                        ccnt_nxt = busy_len;
                    end
                end
            end
            C_SETTLE: begin
                if (ck_rise) begin
                    if (ccnt_r == 6'h01) begin
                        cst_nxt = C_CONV;
                        ccnt_nxt = busy_len;
                    end else begin
                        ccnt_nxt = ccnt_r - 6'h01;
                    end
                end
            end
            C_CONV: begin
                if (ck_rise) begin
                    if (ccnt_r == 6'h01) begin
                        conv_done = 1'b1;
                        if (seq_more) begin
                            ccnt_nxt = busy_len;
                            seq_nxt = seq_idx_r + 2'h1;
                        end else begin
                            cst_nxt = C_IDLE;
                            // per conversion, or after the last of a sequence
                            asleep_nxt = (pd_sel == PD_AUTO_SLEEP);
                        end
                    end else begin
                        ccnt_nxt = ccnt_r - 6'h01;
                    end
                end
            end
            default: begin
                cst_nxt = C_IDLE;
            end
        endcase
        if (pd_sel != PD_AUTO_SLEEP) begin
            asleep_nxt = 1'b0;
        end
    end

    // software reset aborts conversion and returns to acquisition
    always_ff @(posedge clk) begin
        if (ireset) begin
            cst_r <= C_IDLE;
            ccnt_r <= 6'h00;
            seq_idx_r <= 2'h0;
            asleep_r <= 1'b0;
        end else begin
            cst_r <= cst_nxt;
            ccnt_r <= ccnt_nxt;
            seq_idx_r <= seq_nxt;
            asleep_r <= asleep_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (ireset) begin
            since_r <= 6'h3F;
        end else if (start_ok) begin
            since_r <= 6'h00;
        end else if (ck_rise && since_r != 6'h3F) begin
            since_r <= since_r + 6'h01;
        end
    end

    assign busy = (cst_r == C_CONV);
    assign sample_mode = (cst_r != C_CONV);

    // result capture and new-result counter
    logic chan_a_r, chan_b_r, chan_valid_r;
    logic read_ok;

    assign read_ok = rd_fall & ~asleep_r;

    always_ff @(posedge clk) begin
        if (ireset) begin
            result_r <= 32'h00000000;
            chan_a_r <= 1'b0;
            chan_b_r <= 1'b0;
        end else if (conv_done) begin
            result_r <= {result_b, result_a};
            chan_a_r <= channel_a;
            chan_b_r <= channel_b;
        end
    end

    // advance only on a fresh result
    always_ff @(posedge clk) begin
        if (ireset) begin
            cnt_r <= COUNTER_RESET;
        end else if (conv_done && counter_en) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    // channel bit valid for the first full-clock read only
    always_ff @(posedge clk) begin
        if (ireset) begin
            chan_valid_r <= 1'b0;
        end else if (conv_done) begin
            chan_valid_r <= 1'b1;
        end else if (read_ok && full_clock) begin
            chan_valid_r <= 1'b0;
        end
    end

    // first bit is channel indicator or result MSB
    function automatic logic [19:0] frame_of(input logic chan, input logic [15:0] res,
                                             input logic cid_i, input logic bad_chan,
                                             input logic [1:0] cnt_i);
        logic chan_out;
        chan_out = bad_chan ? ~chan : chan;
        if (cid_i) begin
            frame_of = {res, cnt_i, 2'h0};
        end else begin
            frame_of = {chan_out, 1'b0, res, cnt_i};
        end
    endfunction

    // serial readout
    logic [19:0] sha_r, shb_r;
    logic [4:0] sbits_r;
    logic shift_step, bad_chan;

    // falling clock edges in full-clock mode
    // rising clock edges in half-clock mode
    assign shift_step = full_clock ? ck_fall : ck_rise;
    assign bad_chan = full_clock & ~chan_valid_r;

    // a read without a new conversion repeats the stored result
    always_ff @(posedge clk) begin
        if (ireset) begin
            sha_r <= 20'h00000;
            shb_r <= 20'h00000;
            sbits_r <= 5'h00;
        end else if (read_ok) begin
            sha_r <= frame_of(chan_a_r, result_r[15:0], channel_id_disable, bad_chan, cnt_r);
            shb_r <= frame_of(chan_b_r, result_r[31:16], channel_id_disable, bad_chan, cnt_r);
            sbits_r <= FRAME_BITS;
        end else if (shift_step && sbits_r != 5'h00) begin
            sha_r <= {sha_r[18:0], 1'b0};
            shb_r <= {shb_r[18:0], 1'b0};
            sbits_r <= sbits_r - 5'h01;
        end
    end

    assign serial_data_outputs = {shb_r[19], sha_r[19]};
    assign serial_data_enable = (sbits_r != 5'h00);

    // power-down sequencing
    logic [PTMR_W-1:0] ptmr_r, ptmr_nxt, wake_load;
    logic deep_r, deep_nxt, wake_step;

    assign wake_load = deep_r ? PTMR_W'(PD_WAKE_CYCLES) : PTMR_W'(settle_len);
    assign wake_step = deep_r ? 1'b1 : ck_rise;

    always_comb begin
        pwr_nxt = pwr_r;
        ptmr_nxt = ptmr_r;
        deep_nxt = deep_r;
        case (pwr_r)
            P_ON: begin
                if (pd_hold && cst_r == C_IDLE) begin
                    pwr_nxt = P_ENTER;
                    deep_nxt = (pd_sel == PD_POWER_DOWN);
                    ptmr_nxt = (pd_sel == PD_POWER_DOWN) ? PTMR_W'(PD_ENTER_CYC)
                                                         : PTMR_W'(SLEEP_ENTER_CYC);
                end
            end
            P_ENTER: begin
                if (pd_sel == PD_NONE) begin
                    pwr_nxt = P_WAKE;
                    ptmr_nxt = wake_load;
                end else if (ptmr_r <= PTMR_W'(1)) begin
                    pwr_nxt = P_OFF;
                end else begin
                    ptmr_nxt = ptmr_r - PTMR_W'(1);
                end
            end
            P_OFF: begin
                if (pd_sel == PD_NONE) begin
                    pwr_nxt = P_WAKE;
                    ptmr_nxt = wake_load;
                end
            end
            P_WAKE: begin
                if (wake_step) begin
                    if (ptmr_r <= PTMR_W'(1)) begin
                        pwr_nxt = P_ON;
                    end else begin
                        ptmr_nxt = ptmr_r - PTMR_W'(1);
                    end
                end
            end
            default: begin
                pwr_nxt = P_ON;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (ireset) begin
            pwr_r <= P_ON;
            ptmr_r <= '0;
            deep_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            ptmr_r <= ptmr_nxt;
            deep_r <= deep_nxt;
        end
    end

    // digital interface stays up, but reads are ignored in auto-sleep; analog blocks off
    assign bias_enable = (pwr_r != P_OFF) & ~asleep_r;
    assign low_current = (pwr_r == P_OFF) | asleep_r;
    assign deep_power_down = (pwr_r == P_OFF) & deep_r;
endmodule : adc_power_counter_readout_ctrl
`default_nettype wire

// file: adc_host_model.sv
/* Host side of the converter control: converter clock, strobes, control
   word and analog results. Assumes clk is the 50 MHz bench clock. */
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
    input wire logic clk,
    output logic adc_clock,
    output logic conversion_start,
    output logic read_strobe,
    output logic serial_data_in,
    output logic [15:0] result_a,
    output logic [15:0] result_b,
    output logic channel_a,
    output logic channel_b,
    input wire logic [1:0] serial_data_outputs
);
    logic [3:0] div_r = 4'h0;
    logic [19:0] frame_a;
    logic [19:0] frame_b;
    initial begin
        {conversion_start, read_strobe, serial_data_in} = '0;
        {result_a, result_b, channel_a, channel_b} = '0;
    end
    always @(posedge clk) begin
        div_r <= div_r + 4'h1;
    end
    assign adc_clock = div_r[3];
    task automatic convert(input logic [15:0] a, input logic [15:0] b, input logic ch);
        @(posedge adc_clock);
        result_a <= a;
        result_b <= b;
        channel_a <= ch;
        channel_b <= ~ch;
        conversion_start <= 1'b1;
        @(posedge adc_clock);
        conversion_start <= 1'b0;
    endtask : convert
    task automatic read(input logic [15:0] w);
        @(posedge adc_clock);
        read_strobe <= 1'b1;
        @(negedge adc_clock);
        read_strobe <= 1'b0;
        serial_data_in <= w[15];
        for (int i = 0; i < 20; i++) begin
            @(posedge adc_clock);
            frame_a[19-i] = serial_data_outputs[0];
            frame_b[19-i] = serial_data_outputs[1];
            if (i > 0 && i < 16) serial_data_in <= w[15-i];
        end
        serial_data_in <= ~serial_data_in;
    endtask : read
endmodule : adc_host_model
`default_nettype wire

// file: adc_ctrl_chk.sv
/* Port assertions for the converter control block.
   Bound into the top module; assumes adc_ctrl_pkg. */
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic busy,
    input wire logic serial_data_enable,
    input wire logic fifo_enable,
    input wire logic sample_mode,
    input wire logic bias_enable,
    input wire logic low_current,
    input wire logic deep_power_down
);
    import adc_ctrl_pkg::*;
    logic full_clock_r;
    wire logic mapped;
    wire logic cfg_wr;
    assign mapped = paddr == ADDR_CONFIG || paddr == ADDR_STATUS || paddr == ADDR_RESULT;
    assign cfg_wr = psel && penable && pwrite && paddr == ADDR_CONFIG;
    always_ff @(posedge clk) begin
        if (rst) full_clock_r <= 1'b0;
        else if (cfg_wr) full_clock_r <= pwdata[CFG_FULL_CLOCK];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong");
    AST_FIFO_OFF: assert property (full_clock_r |-> !fifo_enable)
        else $error("fifo on in full clock");
    AST_PD_AFTER_CONV: assert property (busy |-> !low_current && !deep_power_down)
        else $error("power down during conversion");
    AST_DEEP_OFF: assert property (deep_power_down |-> low_current && !bias_enable)
        else $error("deep power down keeps bias");
    AST_LOW_BIAS: assert property (low_current |-> !bias_enable)
        else $error("bias on at low current");
    AST_BUSY_MIN: assert property ($rose(busy) |-> busy [*8])
        else $error("busy too short");
    AST_SAMPLE: assert property ($rose(busy) |-> $past(sample_mode) && !sample_mode)
        else $error("sampling not left at busy");
    AST_RST_OUT: assert property ($fell(rst) |-> !busy && !serial_data_enable && bias_enable)
        else $error("outputs not reset");
endmodule : adc_ctrl_chk
bind adc_power_counter_readout_ctrl adc_ctrl_chk adc_ctrl_chk_i (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .busy, .serial_data_enable,
    .fifo_enable, .sample_mode, .bias_enable, .low_current, .deep_power_down);
`default_nettype wire

// file: testbench.sv
/* Self-checking bench for the converter control block.
   Assumes adc_host_model as host and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
    import adc_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, serr, channel_id_disable, busy, serial_data_enable, fifo_enable;
    logic adc_clock, conversion_start, read_strobe, serial_data_in, channel_a, channel_b;
    logic sample_mode, bias_enable, low_current, deep_power_down;
    logic [15:0] result_a, result_b, ra, rb;
    logic [1:0] serial_data_outputs, cnt;
    int num_errors = 0;
    int checked = 0;
    always #10 clk = ~clk;
    adc_power_counter_readout_ctrl #(.PD_WAKE_CYCLES(20)) adc_power_counter_readout_ctrl_i (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .adc_clock, .conversion_start, .read_strobe, .serial_data_in, .result_a, .result_b,
        .channel_a, .channel_b, .busy, .serial_data_outputs, .serial_data_enable,
        .fifo_enable, .sample_mode, .bias_enable, .low_current, .deep_power_down);
    adc_host_model adc_host_model_i (.clk, .adc_clock, .conversion_start, .read_strobe,
        .serial_data_in, .result_a, .result_b, .channel_a, .channel_b, .serial_data_outputs);
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wbusy(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy", v, busy)
    endtask : wbusy
    function automatic logic [19:0] xf(input logic c, input logic ch, input logic [15:0] r);
        return c ? {r, cnt, 2'h0} : {ch, 1'b0, r, cnt};
    endfunction : xf
    task automatic results();
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 32'h20, rdata)
        apb(1'b1, 8'h0C, 32'h5);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("slverr", 1'b1, serr)
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, ADDR_CONFIG, f ? 32'h44 : 32'h40);
            apb(1'b0, ADDR_STATUS, 32'h0);
            `CHK("fifo", f == 0, rdata[4])
        end
        cnt = COUNTER_RESET;
        for (int i = 0; i < 5; i++) begin
            channel_id_disable = i[0];
            ra = 16'h9A50 + 16'(i);
            rb = 16'h3C0F - 16'(i);
            apb(1'b1, ADDR_CONFIG, {27'h0, channel_id_disable, 1'b1, i[2], 2'h0});
            adc_host_model_i.convert(ra, rb, i[1]);
            wbusy(1'b1);
            wbusy(1'b0);
            cnt = cnt + 2'h1;
            for (int r = 0; r < 2; r++) begin
                adc_host_model_i.read(16'h0);
                `CHK("frame_a", xf(channel_id_disable, i[1] ^ (i[2] & r[0]), ra), adc_host_model_i.frame_a)
                `CHK("frame_b", xf(channel_id_disable, !i[1] ^ (i[2] & r[0]), rb), adc_host_model_i.frame_b)
            end
        end
        apb(1'b0, ADDR_RESULT, 32'h0);
        `CHK("result", {rb, ra}, rdata)
        ra = 16'h0F1E;
        rb = 16'hE1F0;
        adc_host_model_i.convert(ra, rb, 1'b0);
        wbusy(1'b1);
        apb(1'b1, ADDR_CONFIG, 32'h1);
        wbusy(1'b0);
        apb(1'b0, ADDR_RESULT, 32'h0);
        `CHK("result", {rb, ra}, rdata)
        repeat (1100) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("pd", 2'h3, rdata[3:2])
        apb(1'b0, ADDR_CONFIG, 32'h0);
        `CHK("config", 32'h1, rdata)
        apb(1'b1, ADDR_CONFIG, 32'h0);
        repeat (400) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("wake", 2'h0, rdata[3:2])
        apb(1'b1, ADDR_CONFIG, 32'h2);
        repeat (600) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("sleep", 2'h1, rdata[3:2])
        apb(1'b1, ADDR_CONFIG, 32'h0);
        repeat (200) @(posedge clk);
        apb(1'b1, ADDR_CONFIG, 32'h3);
        adc_host_model_i.convert(ra, rb, 1'b0);
        wbusy(1'b1);
        wbusy(1'b0);
        repeat (600) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("auto", 4'h6, rdata[3:0])
        adc_host_model_i.convert(ra, rb, 1'b0);
        `CHK("settle", 1'b0, busy)
        wbusy(1'b1);
        wbusy(1'b0);
        apb(1'b1, ADDR_CONFIG, 32'h1AB);
        adc_host_model_i.convert(ra, rb, 1'b0);
        wbusy(1'b1);
        wbusy(1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("seq", {cnt + 2'h2, 5'h06}, rdata[6:0])
        adc_host_model_i.read(16'h4000);
        repeat (20) @(posedge clk);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        `CHK("srst_cfg", 32'h0, rdata)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("srst_st", 32'h20, rdata)
        results();
    end
endmodule : testbench
`default_nettype wire
